//--- shared/scp_pkg.sv
// Purpose: constants and carriers for the split commitment and
//          power capability register bank
// Assumes: byte addressed 32-bit configuration words
// Notes:   every offset, field position and reset value lives here
package scp_pkg;
   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [7:0] SCP_OFF_UP_COMMIT = 8'h88;
   localparam logic [7:0] SCP_OFF_DN_COMMIT = 8'h8C;
   localparam logic [7:0] SCP_OFF_PM_CAP = 8'h90;
   localparam logic [7:0] SCP_OFF_STATUS = 8'hF0;
   localparam logic [7:0] SCP_OFF_USAGE = 8'hF4;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int SCP_LIM_LSB = 16;
   localparam int SCP_LIM_MSB = 31;
   localparam int SCP_ST_DN_DELAYED = 0;
   localparam int SCP_ST_UP_DELAYED = 1;

   // ***************************************************
   // reset and fixed values
   // ***************************************************
   localparam logic [15:0] SCP_UP_CAPACITY = 16'h0010;
   localparam logic [15:0] SCP_DN_CAPACITY = 16'h0010;
   localparam logic [15:0] SCP_LIM_RESET = 16'h0010;
   localparam logic [15:0] SCP_LIM_UNLIMITED = 16'hFFFF;
   localparam logic [7:0] SCP_PM_CAP_ID = 8'h01;
   localparam logic [7:0] SCP_PM_NEXT_PTR = 8'hA8;
   localparam logic [2:0] SCP_PM_VERSION = 3'h2;
   localparam logic [0:0] SCP_PM_EVT_CLOCK = 1'h0;
   localparam logic [0:0] SCP_PM_RSVD = 1'h0;
   localparam logic [0:0] SCP_PM_DEV_INIT = 1'h0;
   localparam logic [2:0] SCP_PM_AUX_CURRENT = 3'h1;
   localparam logic [1:0] SCP_PM_D1D2 = 2'h0;
   localparam logic [4:0] SCP_PM_EVT_STATES = 5'h19;
   localparam logic [31:0] SCP_PM_WORD = {SCP_PM_EVT_STATES, SCP_PM_D1D2,
      SCP_PM_AUX_CURRENT, SCP_PM_DEV_INIT, SCP_PM_RSVD, SCP_PM_EVT_CLOCK,
      SCP_PM_VERSION, SCP_PM_NEXT_PTR, SCP_PM_CAP_ID};

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } scp_bus_t;

   typedef struct packed {
      logic valid;
      logic [15:0] size;
   } scp_req_t;

   // room check shared by both directions
   function automatic logic scp_fits(input logic [15:0] used,
      input logic [15:0] size, input logic [15:0] limit);
      logic [16:0] sum;
      sum = {1'b0, used} + {1'b0, size};
      return (limit == SCP_LIM_UNLIMITED) || (sum <= {1'b0, limit});
   endfunction
endpackage

//--- src/scp_commit_gate.sv
// Purpose: commitment accounting for one direction of split requests
// Assumes: requester re-presents a delayed request later
// Notes:   grant and delay are one-cycle registered pulses
`timescale 1ns/1ps
`default_nettype none
module scp_commit_gate
   import scp_pkg::*;
#(
   parameter int W = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // limit and traffic
   input wire logic [W-1:0] limit,
   input wire scp_pkg::scp_req_t req,
   input wire scp_pkg::scp_req_t done,
   // results
   output logic grant_r,
   output logic delay_r,
   output logic [W-1:0] used_r
);
   logic fit;
   logic [W:0] add_nxt;
   logic [W-1:0] used_nxt;

   // room test and running total
   always_comb begin
      fit = scp_fits(used_r, req.size, limit);
      add_nxt = {1'b0, used_r};
      if (req.valid && fit) begin
         add_nxt = {1'b0, used_r} + {1'b0, req.size};
      end
      if (add_nxt[W]) begin
         add_nxt = {1'b0, {W{1'b1}}}; // clamp, unlimited mode can overrun
      end
      if (done.valid) begin
         if (add_nxt[W-1:0] > done.size) begin
            add_nxt = add_nxt - {1'b0, done.size};
         end else begin
            add_nxt = '0;
         end
      end
      used_nxt = add_nxt[W-1:0];
   end

   // forward or hold back each request
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         grant_r <= 1'b0;
         delay_r <= 1'b0;
      end else begin
         grant_r <= req.valid && fit;
         delay_r <= req.valid && !fit;
      end
   end

   // outstanding committed ADQs
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         used_r <= '0;
      end else begin
         used_r <= used_nxt;
      end
   end
endmodule
`default_nettype wire

//--- src/scp_regs.sv
// Purpose: split commitment limits and power capability header
// Assumes: one-cycle strobes, read data valid the cycle after
// Notes:   status flags clear by writing one, set wins
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - upstream capacity field reads sixteen ADQs and cannot be written.
// - downstream capacity field reads sixteen ADQs and cannot be written.
// - upstream commitment limit in bits 31:16 is writable to any value.
// - downstream commitment limit in bits 31:16 is writable and gates forwarding.
// - a limit of all ones lets every split request through.
// - both limits start at sixteen ADQs after reset.
// - a request exceeding the downstream limit is delayed and sets a W1C flag.
// - capability ID byte reads the power capability identifier.
// - next pointer byte points at the subsystem identification entry.
// - version field reads revision 1.1.
// - event clock bit and reserved bit 20 read zero.
// - device specific initialization bit reads zero.
// - auxiliary current field reads the 55mA code.
// - D1 and D2 support bits read zero.
// - event support field reads D3 cold, D3 hot and D0.
module scp_regs
   import scp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire scp_pkg::scp_bus_t bus,
   output logic [31:0] rdata_r,
   // upstream split traffic
   input wire scp_pkg::scp_req_t up_req,
   input wire scp_pkg::scp_req_t up_done,
   output logic up_grant,
   output logic up_delay,
   // downstream split traffic
   input wire scp_pkg::scp_req_t dn_req,
   input wire scp_pkg::scp_req_t dn_done,
   output logic dn_grant,
   output logic dn_delay
);
   import scp_pkg::*;

   logic [15:0] up_lim_r;
   logic [15:0] dn_lim_r;
   logic dn_flag_r;
   logic up_flag_r;
   logic [15:0] up_used;
   logic [15:0] dn_used;
   logic [31:0] rd_nxt;
   logic wr_up;
   logic wr_dn;
   logic wr_st;

   // ***************************************************
   // write decode
   // ***************************************************
   // only the limit words and the status word take writes
   assign wr_up = bus.wr && (bus.addr == SCP_OFF_UP_COMMIT);
   assign wr_dn = bus.wr && (bus.addr == SCP_OFF_DN_COMMIT);
   assign wr_st = bus.wr && (bus.addr == SCP_OFF_STATUS);

   // upstream limit, capacity half of the word is fixed
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         up_lim_r <= SCP_LIM_RESET;
      end else if (wr_up) begin
         up_lim_r <= bus.wdata[SCP_LIM_MSB:SCP_LIM_LSB];
      end
   end

   // downstream limit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dn_lim_r <= SCP_LIM_RESET;
      end else if (wr_dn) begin
         dn_lim_r <= bus.wdata[SCP_LIM_MSB:SCP_LIM_LSB];
      end
   end

   // ***************************************************
   // commitment gates
   // ***************************************************
   // upstream direction, same accounting as downstream
   scp_commit_gate #(
      .W(16)
   ) u_up_gate (
      .sys_clk(sys_clk),
      .rst(rst),
      .limit(up_lim_r),
      .req(up_req),
      .done(up_done),
      .grant_r(up_grant),
      .delay_r(up_delay),
      .used_r(up_used)
   );

   // downstream direction
   scp_commit_gate #(
      .W(16)
   ) u_dn_gate (
      .sys_clk(sys_clk),
      .rst(rst),
      .limit(dn_lim_r),
      .req(dn_req),
      .done(dn_done),
      .grant_r(dn_grant),
      .delay_r(dn_delay),
      .used_r(dn_used)
   );

   // ***************************************************
   // delayed request flags
   // ***************************************************
   // a new delay in the clearing cycle keeps the flag set
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dn_flag_r <= 1'b0;
      end else if (dn_delay) begin
         dn_flag_r <= 1'b1;
      end else if (wr_st && bus.wdata[SCP_ST_DN_DELAYED]) begin
         dn_flag_r <= 1'b0;
      end
   end

   // upstream twin of the flag, same clearing
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         up_flag_r <= 1'b0;
      end else if (up_delay) begin
         up_flag_r <= 1'b1;
      end else if (wr_st && bus.wdata[SCP_ST_UP_DELAYED]) begin
         up_flag_r <= 1'b0;
      end
   end

   // ***************************************************
   // read path
   // ***************************************************
   // unmapped offsets read zero
   always_comb begin
      rd_nxt = '0;
      case (bus.addr)
         SCP_OFF_UP_COMMIT: begin
            rd_nxt = {up_lim_r, SCP_UP_CAPACITY};
         end
         SCP_OFF_DN_COMMIT: begin
            rd_nxt = {dn_lim_r, SCP_DN_CAPACITY};
         end
         SCP_OFF_PM_CAP: begin
            rd_nxt = SCP_PM_WORD;
         end
         SCP_OFF_STATUS: begin
            rd_nxt[SCP_ST_DN_DELAYED] = dn_flag_r;
            rd_nxt[SCP_ST_UP_DELAYED] = up_flag_r;
         end
         SCP_OFF_USAGE: begin
            rd_nxt = {up_used, dn_used};
         end
         default: begin
            rd_nxt = '0;
         end
      endcase
   end

   // data stands one cycle only, zero otherwise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (bus.rd) begin
         rdata_r <= rd_nxt;
      end else begin
         rdata_r <= '0;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   logic rst_seen_r;
   // marks the first cycle after reset release
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rst_seen_r <= 1'b1;
      end else begin
         rst_seen_r <= 1'b0;
      end
   end

   up_capacity_a: assert property (
      bus.rd && bus.addr == SCP_OFF_UP_COMMIT |=> rdata_r[15:0] == 16'h0010)
      else $error("upstream capacity wrong");

   dn_capacity_a: assert property (
      bus.rd && bus.addr == SCP_OFF_DN_COMMIT |=> rdata_r[15:0] == 16'h0010)
      else $error("downstream capacity wrong");

   up_limit_wr_a: assert property (
      wr_up ##1 (bus.rd && bus.addr == SCP_OFF_UP_COMMIT && !wr_up)
      |=> rdata_r[31:16] == $past(bus.wdata[31:16], 2))
      else $error("upstream limit not written");

   dn_limit_wr_a: assert property (
      wr_dn |=> dn_lim_r == $past(bus.wdata[31:16]))
      else $error("downstream limit not written");

   unlimited_pass_a: assert property (
      dn_req.valid && dn_lim_r == 16'hFFFF |=> dn_grant && !dn_delay)
      else $error("unlimited limit blocked a request");

   limit_reset_a: assert property (
      rst_seen_r |-> up_lim_r == 16'h0010 && dn_lim_r == 16'h0010)
      else $error("limit reset value wrong");

   delay_flag_a: assert property (
      dn_req.valid && ({1'b0, dn_used} + {1'b0, dn_req.size} > {1'b0, dn_lim_r})
      && dn_lim_r != 16'hFFFF |=> dn_delay ##1 dn_flag_r)
      else $error("over limit request not delayed");

   flag_clear_a: assert property (
      wr_st && bus.wdata[0] && !dn_delay |=> !dn_flag_r)
      else $error("delayed flag not cleared");

   cap_id_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[7:0] == 8'h01)
      else $error("capability id wrong");

   next_ptr_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[15:8] == 8'hA8)
      else $error("next pointer wrong");

   pm_version_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[18:16] == 3'b010)
      else $error("version wrong");

   clock_rsvd_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[20:19] == 2'b00)
      else $error("clock or reserved bit set");

   dev_init_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> !rdata_r[21])
      else $error("init bit set");

   aux_current_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[24:22] == 3'b001)
      else $error("aux current wrong");

   d1d2_support_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[26:25] == 2'b00)
      else $error("d1 d2 support set");

   event_states_a: assert property (
      bus.rd && bus.addr == SCP_OFF_PM_CAP |=> rdata_r[31:27] == 5'b11001)
      else $error("event support wrong");

   ro_write_a: assert property (
      bus.wr && bus.addr == SCP_OFF_PM_CAP |=> $stable(up_lim_r) && $stable(dn_lim_r))
      else $error("read-only write changed a limit");

   // ***************************************************
   // limit holding and read-back
   // ***************************************************
   // a limit only moves on a write to its own word
   up_limit_keep_a: assert property (
      !wr_up |=> $stable(up_lim_r))
      else $error("upstream limit moved without a write");

   dn_limit_keep_a: assert property (
      !wr_dn |=> $stable(dn_lim_r))
      else $error("downstream limit moved without a write");

   // the limit half of a read shows the register as it stood
   up_limit_rd_a: assert property (
      bus.rd && bus.addr == SCP_OFF_UP_COMMIT |=> rdata_r[31:16] == $past(up_lim_r))
      else $error("upstream limit read back wrong");

   dn_limit_rd_a: assert property (
      bus.rd && bus.addr == SCP_OFF_DN_COMMIT |=> rdata_r[31:16] == $past(dn_lim_r))
      else $error("downstream limit read back wrong");

   // read data must not linger past their one cycle
   rd_idle_zero_a: assert property (
      !bus.rd |=> rdata_r == 32'h0)
      else $error("read data stood without a read");

   unmapped_zero_a: assert property (
      bus.rd && bus.addr != SCP_OFF_UP_COMMIT && bus.addr != SCP_OFF_DN_COMMIT
      && bus.addr != SCP_OFF_PM_CAP && bus.addr != SCP_OFF_STATUS
      && bus.addr != SCP_OFF_USAGE |=> rdata_r == 32'h0)
      else $error("unmapped offset read nonzero");

   usage_rd_a: assert property (
      bus.rd && bus.addr == SCP_OFF_USAGE |=> rdata_r == {$past(up_used), $past(dn_used)})
      else $error("usage read back wrong");

   // ***************************************************
   // gate answers
   // ***************************************************
   // a request that fits is forwarded on the next cycle, there is no hidden queue
   dn_fit_grant_a: assert property (
      dn_req.valid && ({1'b0, dn_used} + {1'b0, dn_req.size} <= {1'b0, dn_lim_r})
      |=> dn_grant && !dn_delay)
      else $error("fitting downstream request held back");

   up_over_delay_a: assert property (
      up_req.valid && ({1'b0, up_used} + {1'b0, up_req.size} > {1'b0, up_lim_r})
      && up_lim_r != 16'hFFFF |=> up_delay && !up_grant)
      else $error("over limit upstream request forwarded");

   up_unlimited_a: assert property (
      up_req.valid && up_lim_r == 16'hFFFF |=> up_grant && !up_delay)
      else $error("unlimited upstream limit blocked a request");

   // answers only ever follow a request
   dn_quiet_a: assert property (
      !dn_req.valid |=> !dn_grant && !dn_delay)
      else $error("downstream answer without request");

   up_quiet_a: assert property (
      !up_req.valid |=> !up_grant && !up_delay)
      else $error("upstream answer without request");

   // ***************************************************
   // delayed request flag checks
   // ***************************************************
   // set wins over a clear landing in the same cycle
   dn_flag_set_a: assert property (
      dn_delay |=> dn_flag_r)
      else $error("downstream delay did not set its flag");

   up_flag_set_a: assert property (
      up_delay |=> up_flag_r)
      else $error("upstream delay did not set its flag");

   up_flag_clear_a: assert property (
      wr_st && bus.wdata[SCP_ST_UP_DELAYED] && !up_delay |=> !up_flag_r)
      else $error("upstream flag not cleared");

   // the flag only moves on a delay or a status write
   dn_flag_hold_a: assert property (
      !dn_delay && !wr_st |=> $stable(dn_flag_r))
      else $error("downstream flag moved by itself");

   status_rd_a: assert property (
      bus.rd && bus.addr == SCP_OFF_STATUS
      |=> rdata_r == {30'h0, $past(up_flag_r), $past(dn_flag_r)})
      else $error("status read back wrong");
endmodule
`default_nettype wire

//--- verif/scp_host_model.sv
// Purpose: host model issuing configuration reads and writes
// Assumes: one-cycle strobes, read data only in the cycle after the strobe
// Notes:   address is inverted while no strobe is up, data only after cfg_write
`timescale 1ns/1ps
`default_nettype none
module scp_host_model
   import scp_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // register port
   output var scp_pkg::scp_bus_t bus,
   input wire logic [31:0] rdata_r
);
   // idle bus at time zero
   initial begin
      bus = '0;
   end

   // one-cycle write; stale fields are inverted so nothing leans on them
   task automatic cfg_write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge sys_clk);
      bus <= '{addr: addr, wdata: data, wr: 1'h1, rd: 1'h0};
      @(posedge sys_clk);
      bus <= '{addr: ~addr, wdata: ~data, wr: 1'h0, rd: 1'h0};
   endtask

   // read data are taken in the single cycle after the strobe
   task automatic cfg_read(input logic [7:0] addr, output logic [31:0] data);
      @(posedge sys_clk);
      bus <= '{addr: addr, wdata: ~bus.wdata, wr: 1'h0, rd: 1'h1};
      @(posedge sys_clk);
      bus <= '{addr: ~addr, wdata: bus.wdata, wr: 1'h0, rd: 1'h0};
      #1 data = rdata_r;
   endtask

   // write then read of one word with no gap between the strobes
   task automatic cfg_write_read(input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] data);
      @(posedge sys_clk);
      bus <= '{addr: addr, wdata: wdata, wr: 1'h1, rd: 1'h0};
      @(posedge sys_clk);
      bus <= '{addr: addr, wdata: ~wdata, wr: 1'h0, rd: 1'h1};
      @(posedge sys_clk);
      bus <= '{addr: ~addr, wdata: wdata, wr: 1'h0, rd: 1'h0};
      #1 data = rdata_r;
   endtask
endmodule
`default_nettype wire

//--- verif/split_commit_and_pm_capability_regs_tb_top.sv
// Purpose: self-checking bench for the split commitment and power capability bank
// Assumes: 25 MHz clock, grant or delay one cycle after a request
// Notes:   each scenario is one task; expectations come from fixed field values
`timescale 1ns/1ps
`default_nettype none
module split_commit_and_pm_capability_regs_tb_top;
   import scp_pkg::*;
   // ***************************************************
   // signals
   // ***************************************************
   logic sys_clk;
   logic rst;
   scp_bus_t bus;
   logic [31:0] rdata_r;
   scp_req_t up_req, up_done, dn_req, dn_done;
   logic up_grant, up_delay, dn_grant, dn_delay;
   int n_mismatch;
   int total_checks;
   int cycles;

   scp_host_model scp_host_model_i (.sys_clk(sys_clk), .bus(bus), .rdata_r(rdata_r));

   scp_regs scp_regs_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata_r(rdata_r),
      .up_req(up_req), .up_done(up_done), .up_grant(up_grant), .up_delay(up_delay),
      .dn_req(dn_req), .dn_done(dn_done), .dn_grant(dn_grant), .dn_delay(dn_delay));

   // 40 ns clock
   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end

   // hang guard, far above the hundred or so cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= 5000) begin
         n_mismatch++;
         test_done();
      end
   end

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] got;
      scp_host_model_i.cfg_read(addr, got);
      chk("read data", exp, got);
   endtask

   // back-to-back write and read, the read must already see the write
   task automatic wr_rd_chk(input logic [7:0] addr, input logic [31:0] data,
      input logic [31:0] exp);
      logic [31:0] got;
      scp_host_model_i.cfg_write_read(addr, data, got);
      chk("read after write", exp, got);
   endtask

   // one request pulse; the answer is a pulse exactly one cycle later
   task automatic split_req(input logic dn, input logic [15:0] size, input logic exp_grant);
      @(posedge sys_clk);
      if (dn) dn_req <= '{valid: 1'h1, size: size};
      else up_req <= '{valid: 1'h1, size: size};
      @(posedge sys_clk);
      dn_req <= '{valid: 1'h0, size: ~size};
      up_req <= '{valid: 1'h0, size: ~size};
      #1;
      chk("grant", {31'h0, exp_grant}, {31'h0, dn ? dn_grant : up_grant});
      chk("delay", {31'h0, ~exp_grant}, {31'h0, dn ? dn_delay : up_delay});
   endtask

   // completion hands commitment back
   task automatic split_done(input logic dn, input logic [15:0] size);
      @(posedge sys_clk);
      if (dn) dn_done <= '{valid: 1'h1, size: size};
      else up_done <= '{valid: 1'h1, size: size};
      @(posedge sys_clk);
      dn_done <= '{valid: 1'h0, size: ~size};
      up_done <= '{valid: 1'h0, size: ~size};
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic test_reset_values();
      rd_chk(8'h88, 32'h0010_0010);
      rd_chk(8'h8C, 32'h0010_0010);
      rd_chk(8'h90, 32'hC842_A801);
      rd_chk(8'h40, 32'h0000_0000);
   endtask

   // read-only fields must shrug off writes of all ones
   task automatic test_ro_writes();
      scp_host_model_i.cfg_write(8'h90, 32'hFFFF_FFFF);
      rd_chk(8'h90, 32'hC842_A801);
      scp_host_model_i.cfg_write(8'h88, 32'hFFFF_FFFF);
      rd_chk(8'h88, 32'hFFFF_0010);
      scp_host_model_i.cfg_write(8'h88, 32'h0000_FFFF);
      rd_chk(8'h88, 32'h0000_0010);
      scp_host_model_i.cfg_write(8'h8C, 32'h1234_5678);
      rd_chk(8'h8C, 32'h1234_0010);
      scp_host_model_i.cfg_write(8'h40, 32'hFFFF_FFFF);
      rd_chk(8'h40, 32'h0000_0000);
      wr_rd_chk(8'h88, 32'h0010_0000, 32'h0010_0010);
      wr_rd_chk(8'h8C, 32'h0010_0000, 32'h0010_0010);
   endtask

   // fill the downstream limit exactly, then one more unit must wait
   task automatic test_dn_gate();
      split_req(1'h1, 16'h0010, 1'h1);
      split_req(1'h1, 16'h0001, 1'h0);
      rd_chk(8'hF0, 32'h0000_0001);
      rd_chk(8'hF4, 32'h0000_0010);
      scp_host_model_i.cfg_write(8'hF0, 32'h0000_0001);
      rd_chk(8'hF0, 32'h0000_0000);
      split_done(1'h1, 16'h0010);
      split_req(1'h1, 16'h0011, 1'h0);
      split_req(1'h1, 16'h0010, 1'h1);
      split_done(1'h1, 16'h0010);
      scp_host_model_i.cfg_write(8'hF0, 32'h0000_0001);
   endtask

   // a small upstream limit gates upstream requests only
   task automatic test_up_gate();
      scp_host_model_i.cfg_write(8'h88, 32'h0002_0000);
      split_req(1'h0, 16'h0002, 1'h1);
      split_req(1'h0, 16'h0001, 1'h0);
      split_req(1'h1, 16'h0001, 1'h1);
      rd_chk(8'hF0, 32'h0000_0002);
      scp_host_model_i.cfg_write(8'hF0, 32'h0000_0002);
      split_done(1'h0, 16'h0002);
      split_done(1'h1, 16'h0001);
   endtask

   // all ones lets anything through, even past sixteen bits of usage
   task automatic test_unlimited();
      scp_host_model_i.cfg_write(8'h88, 32'hFFFF_0000);
      scp_host_model_i.cfg_write(8'h8C, 32'hFFFF_0000);
      split_req(1'h1, 16'h8000, 1'h1);
      split_req(1'h1, 16'h8001, 1'h1);
      split_req(1'h0, 16'hFFFF, 1'h1);
      split_req(1'h0, 16'h0001, 1'h1);
      rd_chk(8'hF0, 32'h0000_0000);
   endtask

   // a second reset in mid-run brings the limits back to capacity
   task automatic test_rereset();
      @(posedge sys_clk);
      rst <= 1'h1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'h0;
      rd_chk(8'h88, 32'h0010_0010);
      rd_chk(8'h8C, 32'h0010_0010);
      split_req(1'h1, 16'h0011, 1'h0);
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      rst = 1'h1;
      up_req = '0;
      up_done = '0;
      dn_req = '0;
      dn_done = '0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'h0;
      test_reset_values();
      test_ro_writes();
      test_dn_gate();
      test_up_gate();
      test_unlimited();
      test_rereset();
      test_done();
   end
endmodule
`default_nettype wire
